/* core/iagc_defines.vh */
// constants for the expander address and event routing register bank
// assumes byte addresses on a 12-bit register port with 32-bit data
`ifndef IAGC_DEFINES_VH
`define IAGC_DEFINES_VH

`define IAGC_AW 12
`define IAGC_OFF_EXP_LO 12'h434
`define IAGC_OFF_EXP_HI 12'h438
`define IAGC_OFF_EVT_CTL 12'h450
`define IAGC_OFF_EVT_STS 12'h454
`define IAGC_OFF_INT_STS 12'h460
`define IAGC_OFF_INT_MSK 12'h464
`define IAGC_OFF_PIN_CFG 12'h468

`define IAGC_EXP0_HI 7
`define IAGC_EXP0_LO 1
`define IAGC_EXP1_HI 15
`define IAGC_EXP1_LO 9
`define IAGC_EXP2_HI 23
`define IAGC_EXP2_LO 17
`define IAGC_EXP3_HI 31
`define IAGC_EXP3_LO 25
`define IAGC_EXP4_HI 7
`define IAGC_EXP4_LO 1

`define IAGC_POL_BIT 0
`define IAGC_EN_HI 5
`define IAGC_EN_LO 1
`define IAGC_ALT_BIT 0

`define IAGC_NPORT 5
`define IAGC_SAW 7
`define IAGC_SELW 3
`define IAGC_ALLW 35

`define IAGC_Z32 32'h0000_0000
`define IAGC_Z35 35'h0_0000_0000
`define IAGC_Z7 7'h00
`define IAGC_Z5 5'h00
`define IAGC_Z1 1'h0
`define IAGC_SEL0 3'h0
`define IAGC_SEL1 3'h1
`define IAGC_SEL2 3'h2
`define IAGC_SEL3 3'h3
`define IAGC_SEL4 3'h4

`endif

/* core/iagc_evt_route.v */
// per-port reroute of hot-plug notifications onto the event pin
// assumes port event levels synchronous to clk
`timescale 1ns/1ps
`include "iagc_defines.vh"

module iagc_evt_route
(
    input wire clk,
    input wire rst_n,
    input wire hot_rst_n,
    input wire [`IAGC_NPORT-1:0] port_evt,
    input wire [`IAGC_NPORT-1:0] reroute_en,
    output reg [`IAGC_NPORT-1:0] evt_sts_ff,
    output reg [`IAGC_NPORT-1:0] legacy_req_ff
);

    genvar gi;
    generate
        for (gi = 0; gi < `IAGC_NPORT; gi = gi + 1)
        begin : g_port
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    evt_sts_ff[gi] <= `IAGC_Z1;
                    legacy_req_ff[gi] <= `IAGC_Z1;
                end
                else if (!hot_rst_n)
                begin
                    evt_sts_ff[gi] <= `IAGC_Z1;
                    legacy_req_ff[gi] <= `IAGC_Z1;
                end
                else
                begin
                    // status only while enabled and signalling
                    evt_sts_ff[gi] <= port_evt[gi] & reroute_en[gi];
                    // enabled port is kept off intx, msi and pme
                    legacy_req_ff[gi] <= port_evt[gi] & ~reroute_en[gi];
                end
            end
        end
    endgenerate

endmodule // iagc_evt_route

/* core/iagc_addr_sel.v */
// picks the stored slave address of the expander being addressed
// assumes exp_sel comes from the smbus master transaction engine
`timescale 1ns/1ps
`include "iagc_defines.vh"

module iagc_addr_sel
(
    input wire clk,
    input wire rst_n,
    input wire [`IAGC_SELW-1:0] exp_sel,
    input wire [`IAGC_ALLW-1:0] exp_addr_all,
    output reg [`IAGC_SAW-1:0] slave_addr_ff,
    output reg sel_bad_ff
);

    reg [`IAGC_SAW-1:0] nxt_slave_addr;
    reg nxt_sel_bad;

    always @*
    begin
        nxt_slave_addr = `IAGC_Z7;
        nxt_sel_bad = 1'b0;
        case (exp_sel)
            `IAGC_SEL0, `IAGC_SEL1, `IAGC_SEL2, `IAGC_SEL3, `IAGC_SEL4:
            begin
                // entries are packed lowest first, one address width each
                nxt_slave_addr = exp_addr_all[exp_sel*`IAGC_SAW +: `IAGC_SAW];
            end
            // reserved selects get address zero and a flag
            default: nxt_sel_bad = 1'b1;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slave_addr_ff <= `IAGC_Z7;
            sel_bad_ff <= `IAGC_Z1;
        end
        else
        begin
            slave_addr_ff <= nxt_slave_addr;
            sel_bad_ff <= nxt_sel_bad;
        end
    end

endmodule // iagc_addr_sel

/* core/iagc_top.v */
// expander address and event routing register bank with event pin
// assumes rst_n is the fundamental reset, hot_rst_n a synchronous
// non-fundamental reset, and all inputs synchronous to clk
// sticky configuration survives hot_rst_n; event and interrupt state do not
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "iagc_defines.vh"

module iagc_top
(
    input wire clk,
    input wire rst_n,
    input wire hot_rst_n,
    input wire [`IAGC_AW-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    input wire [`IAGC_NPORT-1:0] port_evt,
    output wire [`IAGC_NPORT-1:0] legacy_req_ff,
    input wire [`IAGC_SELW-1:0] exp_sel,
    output wire [`IAGC_SAW-1:0] slave_addr_ff,
    output wire sel_bad_ff,
    input wire gpio7_gp_out,
    input wire gpio7_gp_oe,
    output reg gpio7_out_ff,
    output reg gpio7_oe_ff,
    output reg irq_ff
);

    // sticky storage
    reg [`IAGC_SAW-1:0] exp0_addr_ff;
    reg [`IAGC_SAW-1:0] exp1_addr_ff;
    reg [`IAGC_SAW-1:0] exp2_addr_ff;
    reg [`IAGC_SAW-1:0] exp3_addr_ff;
    reg [`IAGC_SAW-1:0] exp4_addr_ff;
    reg pol_ff;
    reg [`IAGC_NPORT-1:0] reroute_en_ff;

    // non-sticky storage
    reg [`IAGC_NPORT-1:0] int_sts_ff;
    reg [`IAGC_NPORT-1:0] int_msk_ff;
    reg alt_en_ff;
    reg [`IAGC_NPORT-1:0] prev_sts_ff;

    reg [`IAGC_NPORT-1:0] nxt_int_sts;
    reg [31:0] nxt_rdata;
    reg nxt_pin;
    reg nxt_oe;

    // next values of the configuration registers and of the interrupt output
    reg [`IAGC_SAW-1:0] nxt_exp0_addr;
    reg [`IAGC_SAW-1:0] nxt_exp1_addr;
    reg [`IAGC_SAW-1:0] nxt_exp2_addr;
    reg [`IAGC_SAW-1:0] nxt_exp3_addr;
    reg [`IAGC_SAW-1:0] nxt_exp4_addr;
    reg nxt_pol;
    reg [`IAGC_NPORT-1:0] nxt_reroute_en;
    reg [`IAGC_NPORT-1:0] nxt_int_msk;
    reg nxt_alt_en;
    reg nxt_irq;

    wire [`IAGC_NPORT-1:0] evt_sts_ff;
    wire [`IAGC_NPORT-1:0] sts_rise;
    wire evt_active;
    wire wr_lo;
    wire wr_hi;
    wire wr_ctl;
    wire wr_ists;
    wire wr_imsk;
    wire wr_pcfg;

    // exact match only, so aliases of the mapped offsets stay unmapped
    assign wr_lo = reg_wr && (reg_addr == `IAGC_OFF_EXP_LO);
    assign wr_hi = reg_wr && (reg_addr == `IAGC_OFF_EXP_HI);
    assign wr_ctl = reg_wr && (reg_addr == `IAGC_OFF_EVT_CTL);
    assign wr_ists = reg_wr && (reg_addr == `IAGC_OFF_INT_STS);
    assign wr_imsk = reg_wr && (reg_addr == `IAGC_OFF_INT_MSK);
    assign wr_pcfg = reg_wr && (reg_addr == `IAGC_OFF_PIN_CFG);

    // write decode for sticky fields; reserved bit positions are never stored
    always @*
    begin
        nxt_exp0_addr = exp0_addr_ff;
        nxt_exp1_addr = exp1_addr_ff;
        nxt_exp2_addr = exp2_addr_ff;
        nxt_exp3_addr = exp3_addr_ff;
        nxt_exp4_addr = exp4_addr_ff;
        nxt_pol = pol_ff;
        nxt_reroute_en = reroute_en_ff;
        if (wr_lo)
        begin
            nxt_exp0_addr = reg_wdata[`IAGC_EXP0_HI:`IAGC_EXP0_LO];
            nxt_exp1_addr = reg_wdata[`IAGC_EXP1_HI:`IAGC_EXP1_LO];
            nxt_exp2_addr = reg_wdata[`IAGC_EXP2_HI:`IAGC_EXP2_LO];
            nxt_exp3_addr = reg_wdata[`IAGC_EXP3_HI:`IAGC_EXP3_LO];
        end
        if (wr_hi)
        begin
            nxt_exp4_addr = reg_wdata[`IAGC_EXP4_HI:`IAGC_EXP4_LO];
        end
        if (wr_ctl)
        begin
            nxt_pol = reg_wdata[`IAGC_POL_BIT];
            // one enable per downstream port, bits 1 to 5
            nxt_reroute_en = reg_wdata[`IAGC_EN_HI:`IAGC_EN_LO];
        end
    end

    // sticky fields see only the fundamental reset, so a hot reset
    // keeps the expander map and the routing choice
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exp0_addr_ff <= `IAGC_Z7;
            exp1_addr_ff <= `IAGC_Z7;
            exp2_addr_ff <= `IAGC_Z7;
            exp3_addr_ff <= `IAGC_Z7;
            exp4_addr_ff <= `IAGC_Z7;
            pol_ff <= `IAGC_Z1;
            reroute_en_ff <= `IAGC_Z5;
        end
        else
        begin
            exp0_addr_ff <= nxt_exp0_addr;
            exp1_addr_ff <= nxt_exp1_addr;
            exp2_addr_ff <= nxt_exp2_addr;
            exp3_addr_ff <= nxt_exp3_addr;
            exp4_addr_ff <= nxt_exp4_addr;
            pol_ff <= nxt_pol;
            reroute_en_ff <= nxt_reroute_en;
        end
    end

    iagc_evt_route u_route
    (
        .clk(clk),
        .rst_n(rst_n),
        .hot_rst_n(hot_rst_n),
        .port_evt(port_evt),
        .reroute_en(reroute_en_ff),
        .evt_sts_ff(evt_sts_ff),
        .legacy_req_ff(legacy_req_ff)
    );

    iagc_addr_sel u_sel
    (
        .clk(clk),
        .rst_n(rst_n),
        .exp_sel(exp_sel),
        .exp_addr_all({exp4_addr_ff, exp3_addr_ff, exp2_addr_ff, exp1_addr_ff, exp0_addr_ff}),
        .slave_addr_ff(slave_addr_ff),
        .sel_bad_ff(sel_bad_ff)
    );

    // an event on any rerouted port asserts the pin in alternate mode
    assign evt_active = |evt_sts_ff;
    assign sts_rise = evt_sts_ff & ~prev_sts_ff;

    // set wins over write-one-to-clear
    always @*
    begin
        nxt_int_sts = int_sts_ff;
        nxt_int_msk = int_msk_ff;
        nxt_alt_en = alt_en_ff;
        if (wr_ists)
        begin
            nxt_int_sts = nxt_int_sts & ~reg_wdata[`IAGC_NPORT-1:0];
        end
        nxt_int_sts = nxt_int_sts | sts_rise;
        if (wr_imsk)
        begin
            nxt_int_msk = reg_wdata[`IAGC_NPORT-1:0];
        end
        if (wr_pcfg)
        begin
            nxt_alt_en = reg_wdata[`IAGC_ALT_BIT];
        end
        // mask bit set means the source may interrupt
        nxt_irq = |(nxt_int_sts & int_msk_ff);
    end

    // non-sticky state also clears on the hot reset
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_sts_ff <= `IAGC_Z5;
            int_msk_ff <= `IAGC_Z5;
            alt_en_ff <= `IAGC_Z1;
            prev_sts_ff <= `IAGC_Z5;
            irq_ff <= `IAGC_Z1;
        end
        else if (!hot_rst_n)
        begin
            // event, interrupt mask and pin mode state; the sticky configuration is left alone
            int_sts_ff <= `IAGC_Z5;
            int_msk_ff <= `IAGC_Z5;
            alt_en_ff <= `IAGC_Z1;
            prev_sts_ff <= `IAGC_Z5;
            irq_ff <= `IAGC_Z1;
        end
        else
        begin
            int_sts_ff <= nxt_int_sts;
            int_msk_ff <= nxt_int_msk;
            alt_en_ff <= nxt_alt_en;
            prev_sts_ff <= evt_sts_ff;
            irq_ff <= nxt_irq;
        end
    end

    // pin 7: event level in alternate mode, plain gpio otherwise
    // oe is forced high in alternate mode: the event pin is push-pull there
    always @*
    begin
        nxt_pin = gpio7_gp_out;
        nxt_oe = gpio7_gp_oe;
        if (alt_en_ff)
        begin
            // polarity 0 drives active low, 1 active high
            nxt_pin = pol_ff ? evt_active : ~evt_active;
            nxt_oe = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio7_out_ff <= `IAGC_Z1;
            gpio7_oe_ff <= `IAGC_Z1;
        end
        else
        begin
            // no event level reaches the pin unless alternate mode
            gpio7_out_ff <= nxt_pin;
            gpio7_oe_ff <= nxt_oe;
        end
    end

    // read mux; reserved bits and unmapped offsets read zero
    always @*
    begin
        nxt_rdata = `IAGC_Z32;
        case (reg_addr)
            `IAGC_OFF_EXP_LO:
            begin
                nxt_rdata[`IAGC_EXP0_HI:`IAGC_EXP0_LO] = exp0_addr_ff;
                nxt_rdata[`IAGC_EXP1_HI:`IAGC_EXP1_LO] = exp1_addr_ff;
                nxt_rdata[`IAGC_EXP2_HI:`IAGC_EXP2_LO] = exp2_addr_ff;
                nxt_rdata[`IAGC_EXP3_HI:`IAGC_EXP3_LO] = exp3_addr_ff;
            end
            `IAGC_OFF_EXP_HI:
            begin
                nxt_rdata[`IAGC_EXP4_HI:`IAGC_EXP4_LO] = exp4_addr_ff;
            end
            `IAGC_OFF_EVT_CTL:
            begin
                nxt_rdata[`IAGC_POL_BIT] = pol_ff;
                nxt_rdata[`IAGC_EN_HI:`IAGC_EN_LO] = reroute_en_ff;
            end
            `IAGC_OFF_EVT_STS:
            begin
                nxt_rdata[`IAGC_EN_HI:`IAGC_EN_LO] = evt_sts_ff;
            end
            `IAGC_OFF_INT_STS:
            begin
                nxt_rdata[`IAGC_NPORT-1:0] = int_sts_ff;
            end
            `IAGC_OFF_INT_MSK:
            begin
                nxt_rdata[`IAGC_NPORT-1:0] = int_msk_ff;
            end
            `IAGC_OFF_PIN_CFG:
            begin
                nxt_rdata[`IAGC_ALT_BIT] = alt_en_ff;
            end
            default:
            begin
                nxt_rdata = `IAGC_Z32;
            end
        endcase
    end

    // data valid only in the cycle after the strobe
    // a read has no side effect, so reads may run back to back
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_ff <= `IAGC_Z32;
        end
        else if (reg_rd)
        begin
            reg_rdata_ff <= nxt_rdata;
        end
        else
        begin
            reg_rdata_ff <= `IAGC_Z32;
        end
    end

endmodule // iagc_top

/* tb/iagc_top_sva.sv */
// port assertions for the expander address and event routing bank
// assumes a bind onto iagc_top, one clock domain
`timescale 1ns/1ps
module iagc_top_sva
(
    input wire clk,
    input wire rst_n,
    input wire hot_rst_n,
    input wire [11:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_ff,
    input wire [4:0] port_evt,
    input wire [4:0] legacy_req_ff,
    input wire [2:0] exp_sel,
    input wire [6:0] slave_addr_ff,
    input wire sel_bad_ff,
    input wire gpio7_gp_out,
    input wire gpio7_gp_oe,
    input wire gpio7_out_ff,
    input wire gpio7_oe_ff,
    input wire irq_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // unmapped places count as all reserved
    function automatic logic [31:0] rsv(input logic [11:0] a);
        case (a)
            12'h434: rsv = 32'h0101_0101;
            12'h438: rsv = 32'hFFFF_FF01;
            12'h450: rsv = 32'hFFFF_FFC0;
            12'h454: rsv = 32'hFFFF_FFC1;
            12'h460, 12'h464: rsv = 32'hFFFF_FFE0;
            12'h468: rsv = 32'hFFFF_FFFE;
            default: rsv = 32'hFFFF_FFFF;
        endcase
    endfunction
    sequence s_read;
        reg_rd;
    endsequence
    sequence s_idle_data;
        reg_rdata_ff == 32'h0000_0000;
    endsequence
    a_rd_idle: assert property (!reg_rd |=> s_idle_data)
        else $error("read data not zero outside read");
    a_rsv_zero: assert property (s_read |=> (reg_rdata_ff & rsv($past(reg_addr))) == 32'h0)
        else $error("reserved bits read nonzero");
    a_sel_bad: assert property (exp_sel > 3'h4 |=> sel_bad_ff && slave_addr_ff == 7'h00)
        else $error("bad select not flagged");
    a_sel_ok: assert property (exp_sel <= 3'h4 |=> !sel_bad_ff)
        else $error("good select flagged");
    a_legacy_sub: assert property (hot_rst_n |=> (legacy_req_ff & ~$past(port_evt)) == 5'h00)
        else $error("legacy request without event");
    a_hot_clear: assert property (!hot_rst_n |=> !irq_ff && legacy_req_ff == 5'h00)
        else $error("hot reset left state");
    a_pin_thru: assert property (!gpio7_oe_ff |-> gpio7_out_ff == $past(gpio7_gp_out) && !$past(gpio7_gp_oe))
        else $error("pin not passed through");
    a_irq_cause: assert property ($rose(irq_ff) |-> $past(port_evt, 2) != 5'h00 || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt without cause");
endmodule // iagc_top_sva

/* tb/iagc_far_end.sv */
// far side model: hot-plug event sources and the expander engine select
// assumes bench commands change just after a rising clk
`timescale 1ns/1ps
module iagc_far_end
(
    input wire clk,
    input wire rst_n,
    input wire [4:0] evt_cmd,
    input wire [2:0] sel_cmd,
    output logic [4:0] evt_ff,
    output logic [2:0] sel_ff
);
    // registered, as real port logic would be; adds one cycle of latency
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_ff <= 5'h00;
            sel_ff <= 3'h0;
        end
        else
        begin
            evt_ff <= evt_cmd;
            sel_ff <= sel_cmd;
        end
    end
endmodule // iagc_far_end

/* tb/testbench.sv */
// self-checking bench for the expander address and event routing bank
// assumes iagc_top, the far-end model and the checker compiled first
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic hot_rst_n = 1'h1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [4:0] evt_cmd = 5'h00;
    logic [2:0] sel_cmd = 3'h0;
    logic gp_out = 1'h0;
    logic gp_oe = 1'h0;
    wire [31:0] rdata;
    wire [4:0] port_evt;
    wire [4:0] legacy;
    wire [2:0] exp_sel;
    wire [6:0] saddr;
    wire sel_bad;
    wire pin_out;
    wire pin_oe;
    wire irq;
    int fail_count = 0;
    int checked = 0;
    int x;
    int p;
    logic [31:0] lo, hi, ctl, cfg, msk, sts, d;
    logic [4:0] ev;
    logic [11:0] ad [9] = '{12'h434, 12'h438, 12'h450, 12'h454, 12'h460,
        12'h464, 12'h468, 12'h43C, 12'h000};
    iagc_top dut
    (
        .clk(clk), .rst_n(rst_n), .hot_rst_n(hot_rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
        .port_evt(port_evt), .legacy_req_ff(legacy), .exp_sel(exp_sel),
        .slave_addr_ff(saddr), .sel_bad_ff(sel_bad), .gpio7_gp_out(gp_out),
        .gpio7_gp_oe(gp_oe), .gpio7_out_ff(pin_out), .gpio7_oe_ff(pin_oe), .irq_ff(irq)
    );
    iagc_far_end u_far
    (
        .clk(clk), .rst_n(rst_n), .evt_cmd(evt_cmd), .sel_cmd(sel_cmd),
        .evt_ff(port_evt), .sel_ff(exp_sel)
    );
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t pin got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_sel(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t sel got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rv(input logic [11:0] a);
        case (a)
            12'h434: return lo;
            12'h438: return hi;
            12'h450: return ctl;
            12'h454: return {ev & ctl[5:1], 1'h0};
            12'h460: return sts;
            12'h464: return msk;
            12'h468: return cfg;
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [7:0] pin_exp();
        logic a;
        a = (ev & ctl[5:1]) != 5'h00;
        return {ev & ~ctl[5:1], cfg[0] | gp_oe, cfg[0] ? ctl[0] ~^ a : gp_out,
            (sts & msk) != 32'h0};
    endfunction
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk_reg(rdata, rv(a));
    endtask
    task automatic put(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'h0;
        case (a)
            12'h434: lo = v & 32'hFEFE_FEFE;
            12'h438: hi = v & 32'h0000_00FE;
            12'h450: ctl = v & 32'h0000_003F;
            12'h460: sts = sts & ~v;
            12'h464: msk = v & 32'h0000_001F;
            12'h468: cfg = v & 32'h0000_0001;
        endcase
    endtask
    task automatic rd_all();
        for (int i = 0; i < 9; i++)
            rd(ad[i]);
    endtask
    task automatic wrap_up();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(74783));
        {lo, hi, ctl, cfg, msk, sts, ev} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        rd_all();
        repeat (4)
        begin
            for (x = 0; x < 3; x++)
            begin
                put(ad[x], $urandom);
                rd(ad[x]);
            end
            put(12'h43C, $urandom);
            put(12'h454, $urandom);
            rd_all();
            for (x = 0; x < 8; x++)
            begin
                @(posedge clk);
                sel_cmd <= x[2:0];
                repeat (3) @(posedge clk);
                d = x < 4 ? (lo >> (8 * x + 1)) & 32'h7F : x == 4 ? hi >> 1 : 32'h80;
                #1 chk_sel({sel_bad, saddr}, d[7:0]);
            end
        end
        // each port in both polarities, random enables, routing and mask
        for (x = 0; x < 10; x++)
        begin
            p = x % 5;
            d = ($urandom & 32'hFFFF_FFC0) | (($urandom & 32'h1F) << 1) | (x / 5);
            put(12'h450, d);
            put(12'h464, $urandom);
            put(12'h468, $urandom);
            d = $urandom;
            gp_out <= d[0];
            gp_oe <= d[1];
            evt_cmd <= 5'h01 << p;
            ev = 5'h01 << p;
            if (ctl[p + 1])
                sts = sts | (32'h1 << p);
            repeat (5) @(posedge clk);
            #1 chk_pin({legacy, pin_oe, pin_out, irq}, pin_exp());
            rd(12'h454);
            rd(12'h460);
            @(posedge clk);
            evt_cmd <= 5'h00;
            ev = 5'h00;
            repeat (5) @(posedge clk);
            #1 chk_pin({legacy, pin_oe, pin_out, irq}, pin_exp());
            put(12'h460, 32'hFFFF_FFFF);
            repeat (3) @(posedge clk);
            #1 chk_pin({legacy, pin_oe, pin_out, irq}, pin_exp());
        end
        @(posedge clk);
        hot_rst_n <= 1'h0;
        @(posedge clk);
        hot_rst_n <= 1'h1;
        {cfg, msk, sts} = '0;
        rd_all();
        @(posedge clk);
        gp_out <= 1'h0;
        gp_oe <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        {lo, hi, ctl} = '0;
        rd_all();
        wrap_up();
    end
endmodule // testbench
bind iagc_top iagc_top_sva u_sva
(
    .clk(clk), .rst_n(rst_n), .hot_rst_n(hot_rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .port_evt(port_evt),
    .legacy_req_ff(legacy_req_ff), .exp_sel(exp_sel), .slave_addr_ff(slave_addr_ff),
    .sel_bad_ff(sel_bad_ff), .gpio7_gp_out(gpio7_gp_out), .gpio7_gp_oe(gpio7_gp_oe),
    .gpio7_out_ff(gpio7_out_ff), .gpio7_oe_ff(gpio7_oe_ff), .irq_ff(irq_ff)
);
